/* rtl/srfm_pkg.sv */
package srfm_pkg;

  // ==========================================================
  // timing
  localparam int CORE_MHZ      = 20;
  localparam int LFO_KHZ       = 262;
  localparam int DGL_US        = 25;
  localparam int DGL_TICKS     = (DGL_US * LFO_KHZ + 999) / 1000;
  localparam int DG_CNT_W      = 4;
  localparam int BLANK_MS      = 2;
  localparam int BLANK_TICKS   = BLANK_MS * LFO_KHZ;
  // oscillator window in 0.1 kHz units: 196.5 and 327.5 kHz
  localparam int LFO_MIN_DKHZ  = 1965;
  localparam int LFO_MAX_DKHZ  = 3275;
  localparam int LFO_LONG_CYC  = (CORE_MHZ * 10000 + LFO_MIN_DKHZ - 1) / LFO_MIN_DKHZ;
  localparam int LFO_SHORT_CYC = (CORE_MHZ * 10000) / LFO_MAX_DKHZ;
  localparam int CRC_COM_US    = 2;
  localparam int CRC_COM_CYC   = CRC_COM_US * CORE_MHZ;
  localparam int NVM_CRC_MS    = 2;
  localparam int NVM_CRC_CYC   = NVM_CRC_MS * 1000 * CORE_MHZ;
  localparam int VBIST_US      = 4500;
  localparam int TBIST_US      = 2400;
  localparam int BIST_SLOTS    = 6;
  localparam int VSLOT_TICKS   = VBIST_US * LFO_KHZ / 1000 / BIST_SLOTS;
  localparam int TSLOT_TICKS   = TBIST_US * LFO_KHZ / 1000 / BIST_SLOTS;

  // ==========================================================
  // comparator bank positions
  localparam int DG_DIGITAL_LDO_RAIL_POR  = 0;
  localparam int DG_BIAS_OV   = 1;
  localparam int DG_BIAS_UV   = 2;
  localparam int DG_VBIST     = 3;
  localparam int DG_TBIST     = 4;
  localparam int DG_AREF_UV   = 5;
  localparam int DG_AON_OV    = 6;
  localparam int DG_AON_UV    = 7;
  localparam int DG_AON_SW    = 8;
  localparam int DG_BALANCE_PIN_COMPARE      = 9;
  localparam int DG_CELL_INPUT_LOW_COMPARE     = 10;
  localparam int DG_TSHUT     = 11;
  localparam int DG_DGND      = 12;
  localparam int DG_XGND      = 13;
  localparam int DG_AOSC      = 14;
  localparam int DG_BOSC      = 15;
  localparam int DG_MOSC      = 16;
  localparam int DG_AOV       = 17;
  localparam int DG_XOV       = 18;
  localparam int DG_DOV       = 19;
  localparam int DG_ANALOG_LDO_RAIL_UV   = 20;
  localparam int DG_DIGITAL_LDO_RAIL_DRST = 21;
  localparam int DG_TRANSCEIVER_SUPPLY_IN_UV   = 22;
  localparam int DG_NUM       = 23;

  // ==========================================================
  // registers
  localparam logic [7:0] REG_RAIL  = 8'h00;
  localparam logic [7:0] REG_SYSA  = 8'h04;
  localparam logic [7:0] REG_SYSB  = 8'h08;
  localparam logic [7:0] REG_SYSC  = 8'h0C;
  localparam logic [7:0] REG_CTRLB = 8'h10;
  localparam logic [7:0] REG_STAT  = 8'h14;
  localparam logic [7:0] FLAG_RST  = 8'h00;
  localparam logic [7:0] CTRLB_RST = 8'h00;
  localparam logic [7:0] CTRLB_MSK = 8'h03;
  localparam int RF_AOV = 0;
  localparam int RF_XOV = 1;
  localparam int RF_DOV = 2;
  localparam int RF_AUV = 3;
  localparam int RF_BOV = 4;
  localparam int RF_BUV = 5;
  localparam int RF_CUV = 6;
  localparam int SA_AON_OV = 0;
  localparam int SA_AREF   = 1;
  localparam int SA_TSHUT  = 2;
  localparam int SA_AON_SW = 3;
  localparam int SA_BALANCE_PIN_COMPARE   = 4;
  localparam int SA_CELL_INPUT_LOW_COMPARE  = 5;
  localparam int SB_DGND = 0;
  localparam int SB_XGND = 1;
  localparam int SB_AOSC = 2;
  localparam int SB_BOSC = 3;
  localparam int SB_MOSC = 4;
  localparam int SC_LFO   = 0;
  localparam int SC_VBIST = 1;
  localparam int SC_TBIST = 2;
  localparam int CB_BIAS_EN = 0;
  localparam int CB_BIST_EN = 1;
  localparam int ST_VSEL  = 0;
  localparam int ST_TSEL  = 3;
  localparam int ST_READY = 6;

  typedef enum logic [1:0] {
    BS_OFF   = 2'b00,
    BS_BLANK = 2'b01,
    BS_READY = 2'b10
  } srfm_bias_state_type;

endpackage

/* rtl/srfm_deglitch.sv */
`timescale 1ns/100ps
module srfm_deglitch
  import srfm_pkg::*;
#(
  parameter int W = DG_NUM
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  // oscillator tick and comparators
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_raw,
  input  wire logic [W-1:0] i_en,
  // synchronised and qualified levels
  output logic      [W-1:0] o_sync,
  output logic      [W-1:0] o_qual
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // three-stage synchroniser, level moves when stages 2 and 3 agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      o_sync <= '0;
    end else begin
      s1     <= i_raw;
      s2     <= s1;
      s3     <= s2;
      o_sync <= (s2 & s3) | (o_sync & (s2 ^ s3));
    end
  end

  // ==========================================================
  // per-bit persistence counters on the oscillator tick
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [DG_CNT_W-1:0] cnt;
    logic                qual;
    always_ff @(posedge i_core_clk) begin
      if (i_rst || !o_sync[i] || !i_en[i]) begin
        cnt  <= '0;
        qual <= 1'b0;
      end else begin
        if (i_tick && cnt != DG_CNT_W'(DGL_TICKS)) begin
          cnt <= cnt + 1'b1;
        end
        qual <= (cnt == DG_CNT_W'(DGL_TICKS));
      end
    end
    assign o_qual[i] = qual;
  end

  // ==========================================================
  default clocking a_clk @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_dgl_restart: assert property (
    !o_sync[DG_DIGITAL_LDO_RAIL_POR] |=> !o_qual[DG_DIGITAL_LDO_RAIL_POR])
    else $error("qualified level survived a release");
  a_dgl_count: assert property (
    $rose(o_qual[DG_AON_OV]) |-> g_bit[DG_AON_OV].cnt == DG_CNT_W'(DGL_TICKS))
    else $error("qualified before full persistence count");

endmodule

/* rtl/srfm_monitor.sv */
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
module srfm_monitor
  import srfm_pkg::*;
#(
  parameter int P_NVM_CRC_CYC = NVM_CRC_CYC
) (
  // clock and power-on reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // oscillator and comparator bank
  input  wire logic              i_lfo,
  input  wire logic [DG_NUM-1:0] i_cmp,
  // frame check
  input  wire logic              i_frame_end,
  input  wire logic              i_frame_crc_ok,
  // register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [7:0]        i_wr_data,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rd_data,
  // supervision
  output logic                   o_digital_reset,
  output logic                   o_power_down,
  output logic                   o_thermal_shutdown,
  output logic                   o_bias_ref_power,
  output logic                   o_temp_prot_enable,
  output logic      [2:0]        o_volt_bist_sel,
  output logic      [2:0]        o_temp_bist_sel,
  output logic                   o_crc_done,
  output logic                   o_crc_err,
  output logic                   o_nvm_crc_start
);

  localparam int A_CRC_MAX = CRC_COM_CYC;

  function automatic logic [7:0] clr_mask(input logic [7:0] reg_addr);
    return (i_wr && i_addr == reg_addr) ? i_wr_data : 8'h00;
  endfunction

  function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic [7:0] clr);
    return set | (cur & ~clr);
  endfunction

  function automatic logic [2:0] sel_next(input logic [2:0] cur);
    return (cur == 3'(BIST_SLOTS - 1)) ? 3'h0 : cur + 3'h1;
  endfunction

  logic [2:0]          lfo_sync;
  logic                lfo_lvl;
  logic                lfo_prev;
  logic                tick;
  logic [6:0]          lfo_per;
  logic                lfo_armed;
  logic                lfo_bad;
  logic [DG_NUM-1:0]   dg_en;
  logic [DG_NUM-1:0]   dg_sync;
  logic [DG_NUM-1:0]   dg_qual;
  logic                dig_rst;
  logic [7:0]          ctrl_b;
  logic                bist_en;
  srfm_bias_state_type bias_state;
  logic                bias_ready;
  logic [9:0]          blank_cnt;
  logic [7:0]          vslot;
  logic [7:0]          tslot;
  logic [15:0]         nvm_cnt;
  logic [7:0]          rail;
  logic [7:0]          sys_a;
  logic [7:0]          sys_b;
  logic [7:0]          sys_c;
  logic [7:0]          set_rail;
  logic [7:0]          set_sysa;
  logic [7:0]          set_sysb;
  logic [7:0]          set_sysc;
  logic [7:0]          stat;

  // ==========================================================
  // oscillator tick and frequency check
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lfo_sync <= 3'h0;
      lfo_lvl  <= 1'b0;
      lfo_prev <= 1'b0;
    end else begin
      lfo_sync <= {lfo_sync[1:0], i_lfo};
      if (lfo_sync[1] == lfo_sync[2]) begin
        lfo_lvl <= lfo_sync[2];
      end
      lfo_prev <= lfo_lvl;
    end
  end

  assign tick = lfo_lvl & ~lfo_prev;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lfo_per   <= 7'h00;
      lfo_armed <= 1'b0;
      lfo_bad   <= 1'b0;
    end else if (tick) begin
      lfo_per   <= 7'h01;
      lfo_armed <= 1'b1;
      lfo_bad   <= lfo_armed && (lfo_per < 7'(LFO_SHORT_CYC));
    end else begin
      if (lfo_per != 7'h7F) begin
        lfo_per <= lfo_per + 7'h01;
      end
      lfo_bad <= (lfo_per > 7'(LFO_LONG_CYC));
    end
  end

  // ==========================================================
  // comparator qualification
  always_comb begin
    dg_en             = {DG_NUM{1'b1}};
    dg_en[DG_BIAS_OV] = bias_ready;
    dg_en[DG_BIAS_UV] = bias_ready;
    dg_en[DG_VBIST]   = bist_en;
    dg_en[DG_TBIST]   = bist_en & bias_ready;
  end

  srfm_deglitch #(
    .W (DG_NUM)
  ) u_deglitch (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_tick     (tick),
    .i_raw      (i_cmp),
    .i_en       (dg_en),
    .o_sync     (dg_sync),
    .o_qual     (dg_qual)
  );

  // digital reset spares the fault flags
  assign dig_rst = i_rst | dg_sync[DG_DIGITAL_LDO_RAIL_DRST] | dg_sync[DG_ANALOG_LDO_RAIL_UV];

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_digital_reset    <= 1'b1;
      o_power_down       <= 1'b0;
      o_thermal_shutdown <= 1'b0;
    end else begin
      o_digital_reset    <= dig_rst;
      o_power_down       <= dg_qual[DG_DIGITAL_LDO_RAIL_POR] | dg_qual[DG_AON_UV];
      o_thermal_shutdown <= dg_qual[DG_TSHUT];
    end
  end

  // ==========================================================
  // control register and bias reference startup
  always_ff @(posedge i_core_clk) begin
    if (dig_rst) begin
      ctrl_b <= CTRLB_RST;
    end else if (i_wr && i_addr == REG_CTRLB) begin
      ctrl_b <= i_wr_data & CTRLB_MSK;
    end
  end

  assign bist_en          = ctrl_b[CB_BIST_EN];
  assign o_bias_ref_power = ctrl_b[CB_BIAS_EN];
  assign bias_ready       = (bias_state == BS_READY);

  always_ff @(posedge i_core_clk) begin
    if (dig_rst) begin
      bias_state <= BS_OFF;
      blank_cnt  <= 10'h000;
    end else begin
      unique case (bias_state)
        BS_OFF: begin
          blank_cnt <= 10'h000;
          if (ctrl_b[CB_BIAS_EN]) begin
            bias_state <= BS_BLANK;
          end
        end
        BS_BLANK: begin
          if (!ctrl_b[CB_BIAS_EN]) begin
            bias_state <= BS_OFF;
          end else if (blank_cnt == 10'(BLANK_TICKS)) begin
            bias_state <= BS_READY;
          end else if (tick) begin
            blank_cnt <= blank_cnt + 10'h001;
          end
        end
        BS_READY: begin
          if (!ctrl_b[CB_BIAS_EN]) begin
            bias_state <= BS_OFF;
          end
        end
        default: bias_state <= BS_OFF;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_temp_prot_enable <= 1'b0;
    end else begin
      o_temp_prot_enable <= bias_ready;
    end
  end

  // ==========================================================
  // self-test round-robin, counted from setting the self-test enable bit
  always_ff @(posedge i_core_clk) begin
    if (dig_rst || !bist_en) begin
      vslot           <= 8'h00;
      o_volt_bist_sel <= 3'h0;
    end else if (tick) begin
      if (vslot == 8'(VSLOT_TICKS - 1)) begin
        vslot           <= 8'h00;
        o_volt_bist_sel <= sel_next(o_volt_bist_sel);
      end else begin
        vslot <= vslot + 8'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (dig_rst || !bist_en) begin
      tslot           <= 8'h00;
      o_temp_bist_sel <= 3'h0;
    end else if (tick) begin
      if (tslot == 8'(TSLOT_TICKS - 1)) begin
        tslot           <= 8'h00;
        o_temp_bist_sel <= sel_next(o_temp_bist_sel);
      end else begin
        tslot <= tslot + 8'h01;
      end
    end
  end

  // ==========================================================
  // frame and nonvolatile checks
  always_ff @(posedge i_core_clk) begin
    if (dig_rst) begin
      o_crc_done <= 1'b0;
      o_crc_err  <= 1'b0;
    end else begin
      o_crc_done <= i_frame_end;
      o_crc_err  <= i_frame_end & ~i_frame_crc_ok;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (dig_rst) begin
      nvm_cnt         <= 16'h0000;
      o_nvm_crc_start <= 1'b0;
    end else if (nvm_cnt == 16'(P_NVM_CRC_CYC - 1)) begin
      nvm_cnt         <= 16'h0000;
      o_nvm_crc_start <= 1'b1;
    end else begin
      nvm_cnt         <= nvm_cnt + 16'h0001;
      o_nvm_crc_start <= 1'b0;
    end
  end

  // ==========================================================
  // sticky fault flags
  always_comb begin
    set_rail            = 8'h00;
    set_rail[RF_AOV]    = dg_qual[DG_AOV];
    set_rail[RF_XOV]    = dg_qual[DG_XOV];
    set_rail[RF_DOV]    = dg_qual[DG_DOV];
    set_rail[RF_AUV]    = dg_sync[DG_ANALOG_LDO_RAIL_UV];
    set_rail[RF_BOV]    = dg_qual[DG_BIAS_OV];
    set_rail[RF_BUV]    = dg_qual[DG_BIAS_UV];
    set_rail[RF_CUV]    = dg_sync[DG_TRANSCEIVER_SUPPLY_IN_UV];
    set_sysa            = 8'h00;
    set_sysa[SA_AON_OV] = dg_qual[DG_AON_OV];
    set_sysa[SA_AREF]   = dg_qual[DG_AREF_UV];
    set_sysa[SA_TSHUT]  = dg_qual[DG_TSHUT];
    set_sysa[SA_AON_SW] = dg_qual[DG_AON_SW];
    set_sysa[SA_BALANCE_PIN_COMPARE]   = dg_qual[DG_BALANCE_PIN_COMPARE];
    set_sysa[SA_CELL_INPUT_LOW_COMPARE]  = dg_qual[DG_CELL_INPUT_LOW_COMPARE];
    set_sysb            = 8'h00;
    set_sysb[SB_DGND]   = dg_qual[DG_DGND];
    set_sysb[SB_XGND]   = dg_qual[DG_XGND];
    set_sysb[SB_AOSC]   = dg_qual[DG_AOSC];
    set_sysb[SB_BOSC]   = dg_qual[DG_BOSC];
    set_sysb[SB_MOSC]   = dg_qual[DG_MOSC];
    set_sysc            = 8'h00;
    set_sysc[SC_LFO]    = lfo_bad;
    set_sysc[SC_VBIST]  = dg_qual[DG_VBIST];
    set_sysc[SC_TBIST]  = dg_qual[DG_TBIST];
  end

  // write one to clear; a coincident set wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rail  <= FLAG_RST;
      sys_a <= FLAG_RST;
      sys_b <= FLAG_RST;
      sys_c <= FLAG_RST;
    end else begin
      rail  <= flag_next(rail, set_rail, clr_mask(REG_RAIL));
      sys_a <= flag_next(sys_a, set_sysa, clr_mask(REG_SYSA));
      sys_b <= flag_next(sys_b, set_sysb, clr_mask(REG_SYSB));
      sys_c <= flag_next(sys_c, set_sysc, clr_mask(REG_SYSC));
    end
  end

  // ==========================================================
  // register reads
  always_comb begin
    stat              = 8'h00;
    stat[ST_VSEL+:3]  = o_volt_bist_sel;
    stat[ST_TSEL+:3]  = o_temp_bist_sel;
    stat[ST_READY]    = bias_ready;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_rd) begin
      o_rd_data <= 8'h00;
    end else begin
      case (i_addr)
        REG_RAIL:  o_rd_data <= rail;
        REG_SYSA:  o_rd_data <= sys_a;
        REG_SYSB:  o_rd_data <= sys_b;
        REG_SYSC:  o_rd_data <= sys_c;
        REG_CTRLB: o_rd_data <= ctrl_b;
        REG_STAT:  o_rd_data <= stat;
        default:   o_rd_data <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking a_clk @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_por_request: assert property (
    dg_qual[DG_DIGITAL_LDO_RAIL_POR] |=> o_power_down)
    else $error("power-on fault did not power down");
  a_blank_expiry: assert property (
    $rose(bias_ready) |-> $past(blank_cnt) == 10'(BLANK_TICKS))
    else $error("blanking ended early");
  a_bias_gate: assert property (
    !bias_ready [*2] |-> !dg_qual[DG_BIAS_OV] && !dg_qual[DG_BIAS_UV])
    else $error("bias check active during blanking");
  a_bist_gate: assert property (
    !bist_en [*2] |-> !dg_qual[DG_VBIST])
    else $error("self-test result used while disabled");
  a_thermal_stop: assert property (
    dg_qual[DG_TSHUT] |=> o_thermal_shutdown && sys_a[SA_TSHUT])
    else $error("thermal shutdown missed");
  a_ground_open: assert property (
    dg_qual[DG_DGND] |=> sys_b[SB_DGND])
    else $error("ground open flag missed");
  a_osc_flag: assert property (
    dg_qual[DG_MOSC] |=> sys_b[SB_MOSC])
    else $error("oscillation flag missed");
  a_lfo_stall: assert property (
    !tick && lfo_per > 7'(LFO_LONG_CYC) |-> ##2 sys_c[SC_LFO])
    else $error("slow oscillator not flagged");
  a_crc_time: assert property (
    i_frame_end |-> ##[1:A_CRC_MAX] o_crc_done)
    else $error("frame check too slow");
  a_nvm_period: assert property (
    nvm_cnt < 16'(P_NVM_CRC_CYC))
    else $error("nonvolatile check period exceeded");
  a_vbist_step: assert property (
    tick && bist_en && !dig_rst && vslot == 8'(VSLOT_TICKS - 1)
      |=> o_volt_bist_sel != $past(o_volt_bist_sel))
    else $error("voltage self-test did not advance");
  a_tbist_step: assert property (
    tick && bist_en && !dig_rst && tslot == 8'(TSLOT_TICKS - 1)
      |=> o_temp_bist_sel != $past(o_temp_bist_sel))
    else $error("temperature self-test did not advance");
  a_analog_ldo_rail_uv: assert property (
    dg_sync[DG_ANALOG_LDO_RAIL_UV] |=> o_digital_reset && rail[RF_AUV])
    else $error("analog undervoltage not handled");
  a_digital_ldo_rail_reset: assert property (
    dg_sync[DG_DIGITAL_LDO_RAIL_DRST] |=> o_digital_reset && ctrl_b == CTRLB_RST)
    else $error("digital reset not held");
  a_transceiver_supply_in_uv: assert property (
    dg_sync[DG_TRANSCEIVER_SUPPLY_IN_UV] |=> rail[RF_CUV])
    else $error("supply undervoltage not flagged");
  a_flag_sticky: assert property (
    rail[RF_AOV] && !(i_wr && i_addr == REG_RAIL && i_wr_data[RF_AOV]) |=> rail[RF_AOV])
    else $error("flag lost without clear");

  c_bias_ready: cover property ($rose(bias_ready));
  c_power_down: cover property ($rose(o_power_down));
  c_slow_osc:   cover property ($rose(sys_c[SC_LFO]));

endmodule

/* testbench/supply_rail_fault_monitor_test.sv */
`timescale 1ns/100ps
module supply_rail_fault_monitor_test;
  import srfm_pkg::*;
  // ==========================================================
  // signals
  logic              i_core_clk, i_rst, i_lfo, i_frame_end, i_frame_crc_ok, i_wr, i_rd;
  logic [DG_NUM-1:0] i_cmp;
  logic [7:0]        i_addr, i_wr_data, o_rd_data, rd_v;
  logic              o_digital_reset, o_power_down, o_thermal_shutdown, o_bias_ref_power;
  logic              o_temp_prot_enable, o_crc_done, o_crc_err, o_nvm_crc_start, lfo_run;
  logic [2:0]        o_volt_bist_sel, o_temp_bist_sel;
  int                err_count, tests_run, lc, k;

  srfm_monitor #(.P_NVM_CRC_CYC(50)) dut (
    .i_core_clk, .i_rst, .i_lfo, .i_cmp, .i_frame_end, .i_frame_crc_ok,
    .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .o_digital_reset, .o_power_down,
    .o_thermal_shutdown, .o_bias_ref_power, .o_temp_prot_enable, .o_volt_bist_sel,
    .o_temp_bist_sel, .o_crc_done, .o_crc_err, .o_nvm_crc_start);

  // ==========================================================
  // clocks: core 50 ns, oscillator 76 core cycles (about 263 kHz)
  initial begin
    i_core_clk = 0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    lc <= (lc == 37) ? 0 : lc + 1;
    if (lc == 37 && lfo_run) i_lfo <= ~i_lfo;
  end

  // ==========================================================
  // helpers
  task automatic tally_and_finish;
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1;
    cyc(1);
    i_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    cyc(1);
    i_addr <= a;
    i_rd <= 1;
    cyc(1);
    i_rd <= 0;
    rd_v = o_rd_data;
  endtask

  // ==========================================================
  // scenarios
  task automatic dgl(input int idx, input logic [7:0] a, input logic [7:0] m);
    i_cmp[idx] <= 1;
    cyc(228);
    i_cmp[idx] <= 0;
    cyc(20);
    rd(a);
    chk("short pulse", rd_v & m, 8'h00);
    i_cmp[idx] <= 1;
    cyc(380);
    rd(a);
    chk("early", rd_v & m, 8'h00);
    cyc(320);
    i_cmp[idx] <= 0;
    cyc(10);
    rd(a);
    chk("sticky", rd_v & m, m);
    wr(a, m);
    cyc(2);
    rd(a);
    chk("cleared", rd_v, 8'h00);
    $display("test deglitch %0d done", idx);
  endtask
  task automatic frame(input logic ok);
    i_frame_crc_ok <= ok;
    i_frame_end <= 1;
    cyc(1);
    i_frame_end <= 0;
    k = 0;
    while (o_crc_done !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
    chk("crc done", o_crc_done, 1);
    chk("crc err", o_crc_err, !ok);
    cyc(1);
    $display("test frame %0d done", ok);
  endtask
  task automatic hold_out(input int idx, input logic pd, input logic ts);
    i_cmp[idx] <= 1;
    cyc(380);
    chk("early power down", o_power_down, 0);
    chk("early shutdown", o_thermal_shutdown, 0);
    cyc(320);
    chk("power down", o_power_down, pd);
    chk("shutdown", o_thermal_shutdown, ts);
    i_cmp[idx] <= 0;
    cyc(10);
    chk("power down off", o_power_down, 0);
    chk("shutdown off", o_thermal_shutdown, 0);
    $display("test hold %0d done", idx);
  endtask
  task automatic resets;
    i_cmp[DG_TRANSCEIVER_SUPPLY_IN_UV] <= 1;
    cyc(10);
    i_cmp[DG_TRANSCEIVER_SUPPLY_IN_UV] <= 0;
    i_cmp[DG_ANALOG_LDO_RAIL_UV] <= 1;
    cyc(10);
    chk("analog uv reset", o_digital_reset, 1);
    i_cmp[DG_ANALOG_LDO_RAIL_UV] <= 0;
    cyc(10);
    chk("reset released", o_digital_reset, 0);
    rd(REG_RAIL);
    chk("rail causes", rd_v, 8'h48);
    wr(REG_RAIL, 8'h48);
    rd(REG_RAIL);
    chk("rail cleared", rd_v, 8'h00);
    i_cmp[DG_DIGITAL_LDO_RAIL_DRST] <= 1;
    cyc(10);
    chk("digital rail reset", o_digital_reset, 1);
    i_cmp[DG_DIGITAL_LDO_RAIL_DRST] <= 0;
    cyc(10);
    $display("test resets done");
  endtask
  task automatic nvm;
    k = 0;
    while (o_nvm_crc_start !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (o_nvm_crc_start !== 1'b1 && k < 60);
    chk("nvm period", k <= 50, 1);
    $display("test nvm done");
  endtask
  task automatic bias_bist;
    wr(REG_CTRLB, 8'h03);
    cyc(2);
    chk("bias power", o_bias_ref_power, 1);
    i_cmp[DG_BIAS_UV] <= 1;
    cyc(11000);
    chk("temp slot", o_temp_bist_sel, 1);
    chk("volt slot", o_volt_bist_sel, 0);
    cyc(4500);
    chk("temp slot next", o_temp_bist_sel, 1);
    chk("volt slot next", o_volt_bist_sel, 1);
    rd(REG_STAT);
    chk("status", rd_v, 8'h09);
    rd(REG_RAIL);
    chk("blanked bias", rd_v, 8'h00);
    i_cmp[DG_BIAS_UV] <= 0;
    dgl(DG_VBIST, REG_SYSC, 8'h02);
    cyc(22500);
    chk("still blanked", o_temp_prot_enable, 0);
    cyc(1500);
    chk("blank over", o_temp_prot_enable, 1);
    dgl(DG_BIAS_OV, REG_RAIL, 8'h10);
    $display("test bias and self-test done");
  endtask
  task automatic slow_osc;
    lfo_run = 0;
    cyc(300);
    rd(REG_SYSC);
    chk("slow osc", rd_v & 8'h01, 8'h01);
    $display("test slow oscillator done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {i_rst, i_lfo, i_frame_end, i_frame_crc_ok, i_wr, i_rd} = 6'b100000;
    {i_cmp, i_addr, i_wr_data} = '0;
    {err_count, tests_run, lc, lfo_run} = 0;
    lfo_run = 1;
    cyc(4);
    i_rst <= 0;
    cyc(2);
    for (int r = 0; r < 7; r++) begin
      rd(8'(r * 4));
      chk("reset value", rd_v, 8'h00);
    end
    dgl(DG_AON_OV, REG_SYSA, 8'h01);
    dgl(DG_AREF_UV, REG_SYSA, 8'h02);
    dgl(DG_BALANCE_PIN_COMPARE, REG_SYSA, 8'h10);
    dgl(DG_DGND, REG_SYSB, 8'h01);
    dgl(DG_MOSC, REG_SYSB, 8'h10);
    dgl(DG_AOV, REG_RAIL, 8'h01);
    hold_out(DG_DIGITAL_LDO_RAIL_POR, 1, 0);
    hold_out(DG_AON_UV, 1, 0);
    hold_out(DG_TSHUT, 0, 1);
    rd(REG_SYSA);
    chk("thermal flag", rd_v, 8'h04);
    wr(REG_SYSA, 8'h04);
    resets();
    frame(0);
    frame(1);
    nvm();
    bias_bist();
    slow_osc();
    tally_and_finish;
  end

  initial begin
    #3_500_000;
    err_count++;
    tally_and_finish;
  end
endmodule
